/* File: acs_pkg.sv */
// Constants and types shared by the actuator command selector.
package acs_pkg;

    // Clock rate and the one-second base of the start inhibit interval.
    localparam int unsigned ACS_CLK_HZ = 50_000_000;
    localparam int unsigned ACS_TICK_SEC = 1;
    localparam int unsigned ACS_TICKS_PER_SEC = ACS_CLK_HZ * ACS_TICK_SEC;
    localparam int unsigned ACS_SEC_CNT_W = 26;

    // Command source selections.
    localparam logic [2:0] ACS_SRC_NONE = 3'h0;
    localparam logic [2:0] ACS_SRC_MONO_ONE = 3'h1;
    localparam logic [2:0] ACS_SRC_MONO_TWO = 3'h2;
    localparam logic [2:0] ACS_SRC_DUAL = 3'h3;
    localparam logic [2:0] ACS_SRC_LOCAL = 3'h4;
    localparam logic [2:0] ACS_SRC_LOCAL_AUX = 3'h5;
    localparam logic [2:0] ACS_SRC_MONO_ALT = 3'h6;
    localparam logic [2:0] ACS_SRC_TEST = 3'h7;

    // Discrete channel values, normal and alternate decoding.
    localparam logic [1:0] ACS_VAL_STOP = 2'h0;
    localparam logic [1:0] ACS_VAL_OPEN = 2'h1;
    localparam logic [1:0] ACS_VAL_CLOSE = 2'h2;
    localparam logic [1:0] ACS_ALT_CLOSE = 2'h0;
    localparam logic [1:0] ACS_ALT_OPEN = 2'h1;
    localparam logic [1:0] ACS_ALT_STOP = 2'h2;

    // Interlock channel bit positions.
    localparam int unsigned ACS_ILK_OPEN_BIT = 0;
    localparam int unsigned ACS_ILK_CLOSE_BIT = 1;

    // Valve condition codes.
    localparam int unsigned ACS_CODE_STOP = 0;
    localparam int unsigned ACS_CODE_OPEN = 1;
    localparam int unsigned ACS_CODE_CLOSE = 2;
    localparam int unsigned ACS_CODE_OPEN_LIMIT = 9;
    localparam int unsigned ACS_CODE_CLOSED_LIMIT = 10;
    localparam int unsigned ACS_CODE_OPEN_TORQUE = 11;
    localparam int unsigned ACS_CODE_CLOSED_TORQUE = 12;
    localparam int unsigned ACS_CODE_OPENING = 13;
    localparam int unsigned ACS_CODE_CLOSING = 14;
    localparam int unsigned ACS_CODE_AUX_FIRST = 19;
    localparam int unsigned ACS_CODE_INTERLOCK = 25;
    localparam int unsigned ACS_CODE_ESD_FAIL = 33;
    localparam logic [5:0] ACS_CODE_COUNT = 6'h28;

    // Percent of travel and reset values.
    localparam logic [6:0] ACS_PCT_FULL = 7'h64;
    localparam logic [6:0] ACS_PCT_CLOSED = 7'h00;
    localparam logic [7:0] ACS_INHIBIT_RST = 8'hFF;

    // Motion direction, also the positioner state.
    typedef enum logic [1:0] {ACS_DIR_STOP, ACS_DIR_OPEN, ACS_DIR_CLOSE} acs_dir_t;

    // Channels received from the network.
    typedef struct packed {
        logic [1:0] chan_one;
        logic [1:0] chan_two;
        logic [1:0] interlock;
        logic emergency_shutdown;
        logic [6:0] setpoint;
        logic setpoint_strobe;
    } acs_net_cmd_t;

endpackage

/* File: acs_selector.sv */
// Actuator command selector: source arbitration, overrides, positioner and condition reports.
// How it works
// (R1) Source selection 0 ignores every network command; the motor never moves for them.
// (R2) Selection 1 uses channel one, selection 2 channel two; 0 stop, 1 open, 2 close.
// (R3) Selection 6 uses channel one with 0 close, 1 open, 2 stop.
// (R4) Selection 3 accepts both channels, each decoded 0 stop, 1 open, 2 close.
// (R5) In dual mode the most recently changed channel decides.
// (R6) Selections 4, 5 and 7 leave network commands inert.
// (R7) Emergency channel drives to the emergency position, overriding channels one and two.
// (R8) Interlock channel blocks opening, closing or both per its value.
// (R9) Discrete commands outrank the setpoint; setpoint acts only while discrete is stop.
// (R10) After a discrete command, a setpoint equal to the previous one is ignored.
// (R11) On network power loss and return the setpoint is absent; close to 0%.
// (R12) Positioner hysteresis of 0 to 100 percent prevents hunting.
// (R13) Positioner does not start while the error lies inside the deadband.
// (R14) A start inhibit interval of 0 to 255 seconds separates positioner starts.
// (R15) Each report follows one selected condition code from 0 to 39.
// (R16) Codes 9 to 14 are limits, torque trips, travel; 19 to 22 auxiliary inputs.
// (R17) Torque trip codes assert only on torque seating variants.
`timescale 1ns/1ns
module acs_selector #(
    parameter int unsigned TICKS_PER_SEC = acs_pkg::ACS_TICKS_PER_SEC
) (
    input wire logic clk, // 50 MHz clock.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire logic [2:0] source_select, // Command source selection.
    input acs_pkg::acs_net_cmd_t net_cmd, // Channels from the network.
    input wire logic net_power_ok, // Network power present.
    input acs_pkg::acs_dir_t esd_position, // Configured emergency position.
    input wire logic [6:0] hysteresis_pct, // Positioner hysteresis, percent.
    input wire logic [6:0] deadband_pct, // Positioner deadband, percent.
    input wire logic [7:0] start_inhibit_interval, // Seconds between positioner starts.
    input wire logic [6:0] position_pct, // Measured valve position, percent.
    input wire logic limit_open, // Open limit switch.
    input wire logic limit_closed, // Closed limit switch.
    input wire logic torque_open, // Open torque switch.
    input wire logic torque_closed, // Closed torque switch.
    input wire logic torque_seating, // Variant seats on torque.
    input wire logic [3:0] aux_in, // Auxiliary inputs one to four.
    input wire logic [5:0] report_one_code_select, // Code for report one.
    input wire logic [5:0] report_two_code_select, // Code for report two.
    output logic motor_open, // Drive the motor open.
    output logic motor_close, // Drive the motor closed.
    output logic condition_report_one, // Selected code one is true.
    output logic condition_report_two // Selected code two is true.
);

    ////////////////////////////////////////////////////////////////////////////////
    // Helper functions.

    // Decodes a discrete channel value; an undefined value reads as stop.
    function automatic acs_pkg::acs_dir_t decode_val(input logic [1:0] v, input logic alt);
        decode_val = acs_pkg::ACS_DIR_STOP;
        if (alt) begin
            if (v == acs_pkg::ACS_ALT_OPEN) decode_val = acs_pkg::ACS_DIR_OPEN;
            else if (v == acs_pkg::ACS_ALT_CLOSE) decode_val = acs_pkg::ACS_DIR_CLOSE;
        end else begin
            if (v == acs_pkg::ACS_VAL_OPEN) decode_val = acs_pkg::ACS_DIR_OPEN;
            else if (v == acs_pkg::ACS_VAL_CLOSE) decode_val = acs_pkg::ACS_DIR_CLOSE;
        end
    endfunction

    // Picks one condition code; codes past the list read false.
    function automatic logic code_bit(input logic [39:0] vec, input logic [5:0] sel);
        code_bit = (sel < acs_pkg::ACS_CODE_COUNT) ? vec[sel] : 1'b0;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    logic motor_open_reg, motor_close_reg;
    logic report_one_reg, report_two_reg;
    logic [1:0] chan_one_prev_reg, chan_two_prev_reg;
    logic sel_one_reg;
    acs_pkg::acs_dir_t disc_prev_reg, pos_dir_reg, pos_dir_next;
    logic analog_active_reg, analog_active_next;
    logic sp_known_reg;
    logic [6:0] target_reg;
    logic [acs_pkg::ACS_SEC_CNT_W-1:0] sec_cnt_reg;
    logic [7:0] inhibit_cnt_reg;
    logic [39:0] code_vec;

    ////////////////////////////////////////////////////////////////////////////////
    // Source arbitration.

    // Only the four discrete selections let the network move the valve.
    wire net_mode = (source_select == acs_pkg::ACS_SRC_MONO_ONE) || (source_select == acs_pkg::ACS_SRC_MONO_TWO)
                 || (source_select == acs_pkg::ACS_SRC_DUAL) || (source_select == acs_pkg::ACS_SRC_MONO_ALT); // R1 R6
    wire net_live = net_mode && net_power_ok;
    wire alt_mode = (source_select == acs_pkg::ACS_SRC_MONO_ALT); // R3
    wire acs_pkg::acs_dir_t dec_one = decode_val(net_cmd.chan_one, alt_mode); // R2 R3 R4
    wire acs_pkg::acs_dir_t dec_two = decode_val(net_cmd.chan_two, 1'b0); // R2 R4
    wire one_changed = (net_cmd.chan_one != chan_one_prev_reg);
    wire two_changed = (net_cmd.chan_two != chan_two_prev_reg);
    // A fresh change of channel one wins a tie with channel two.
    wire sel_one_now = one_changed ? 1'b1 : (two_changed ? 1'b0 : sel_one_reg); // R5
    wire use_one = (source_select == acs_pkg::ACS_SRC_MONO_ONE) || alt_mode
                || ((source_select == acs_pkg::ACS_SRC_DUAL) && sel_one_now); // R2 R4 R5
    wire acs_pkg::acs_dir_t disc_cmd = !net_live ? acs_pkg::ACS_DIR_STOP : (use_one ? dec_one : dec_two); // R1 R6
    wire disc_stop = (disc_cmd == acs_pkg::ACS_DIR_STOP);
    wire disc_event = (disc_cmd != disc_prev_reg) || !disc_stop; // R10

    // Emergency and interlock overrides.
    wire esd_on = net_live && net_cmd.emergency_shutdown; // R7
    wire ilk_open = net_live && net_cmd.interlock[acs_pkg::ACS_ILK_OPEN_BIT]; // R8
    wire ilk_close = net_live && net_cmd.interlock[acs_pkg::ACS_ILK_CLOSE_BIT]; // R8

    ////////////////////////////////////////////////////////////////////////////////
    // Analogue setpoint and positioner.

    wire [6:0] sp_clamped = (net_cmd.setpoint > acs_pkg::ACS_PCT_FULL) ? acs_pkg::ACS_PCT_FULL : net_cmd.setpoint;
    // A repeated setpoint after a discrete command does nothing.
    wire sp_accept = net_cmd.setpoint_strobe && net_live && disc_stop
                  && (analog_active_reg || !sp_known_reg || (sp_clamped != target_reg)); // R9 R10
    wire pos_engaged = net_mode && disc_stop && analog_active_reg && !esd_on; // R9
    wire [6:0] pos_err = (target_reg > position_pct) ? (target_reg - position_pct) : (position_pct - target_reg);
    wire [6:0] restart_thr = (deadband_pct > hysteresis_pct) ? deadband_pct : hysteresis_pct; // R12 R13
    wire inhibit_ok = (inhibit_cnt_reg >= start_inhibit_interval); // R14
    wire pos_start = pos_engaged && (pos_dir_reg == acs_pkg::ACS_DIR_STOP) && (pos_err > restart_thr)
                  && inhibit_ok; // R12 R13 R14
    wire sec_tick = (sec_cnt_reg == acs_pkg::ACS_SEC_CNT_W'(TICKS_PER_SEC - 1));

    // Positioner runs to the target and then rests until the error leaves the band.
    always_comb begin
        pos_dir_next = pos_dir_reg;
        unique case (pos_dir_reg)
            acs_pkg::ACS_DIR_STOP: begin
                if (pos_start) begin
                    pos_dir_next = (target_reg > position_pct) ? acs_pkg::ACS_DIR_OPEN : acs_pkg::ACS_DIR_CLOSE;
                end
            end
            acs_pkg::ACS_DIR_OPEN: begin
                if (position_pct >= target_reg) pos_dir_next = acs_pkg::ACS_DIR_STOP; // R12
            end
            acs_pkg::ACS_DIR_CLOSE: begin
                if (position_pct <= target_reg) pos_dir_next = acs_pkg::ACS_DIR_STOP; // R12
            end
            default: pos_dir_next = acs_pkg::ACS_DIR_STOP;
        endcase
        if (!pos_engaged) pos_dir_next = acs_pkg::ACS_DIR_STOP;
    end

    // Analogue mode ends on any discrete command and is forced on, closed, without network power.
    always_comb begin
        analog_active_next = analog_active_reg;
        if (!net_power_ok) analog_active_next = 1'b1; // R11
        else if (disc_event) analog_active_next = 1'b0; // R9 R10
        else if (sp_accept) analog_active_next = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Motor drive.

    wire acs_pkg::acs_dir_t dir_want = esd_on ? esd_position : (!disc_stop ? disc_cmd
                                    : (pos_engaged ? pos_dir_reg : acs_pkg::ACS_DIR_STOP)); // R7 R9
    wire block_open = limit_open || (torque_seating && torque_open) || (ilk_open && !esd_on); // R8
    wire block_close = limit_closed || (torque_seating && torque_closed) || (ilk_close && !esd_on); // R8
    // A reversal passes through one cycle of stop so both drives never overlap.
    wire open_next = (dir_want == acs_pkg::ACS_DIR_OPEN) && !block_open && !motor_close_reg;
    wire close_next = (dir_want == acs_pkg::ACS_DIR_CLOSE) && !block_close && !motor_open_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Condition codes.

    // Builds the code list; torque codes need a torque seating variant.
    always_comb begin
        code_vec = '0;
        code_vec[acs_pkg::ACS_CODE_STOP] = (dir_want == acs_pkg::ACS_DIR_STOP);
        code_vec[acs_pkg::ACS_CODE_OPEN] = (dir_want == acs_pkg::ACS_DIR_OPEN);
        code_vec[acs_pkg::ACS_CODE_CLOSE] = (dir_want == acs_pkg::ACS_DIR_CLOSE);
        code_vec[acs_pkg::ACS_CODE_OPEN_LIMIT] = limit_open; // R16
        code_vec[acs_pkg::ACS_CODE_CLOSED_LIMIT] = limit_closed; // R16
        code_vec[acs_pkg::ACS_CODE_OPEN_TORQUE] = torque_seating && torque_open; // R16 R17
        code_vec[acs_pkg::ACS_CODE_CLOSED_TORQUE] = torque_seating && torque_closed; // R16 R17
        code_vec[acs_pkg::ACS_CODE_OPENING] = motor_open_reg; // R16
        code_vec[acs_pkg::ACS_CODE_CLOSING] = motor_close_reg; // R16
        code_vec[acs_pkg::ACS_CODE_AUX_FIRST +: 4] = aux_in; // R16
        code_vec[acs_pkg::ACS_CODE_INTERLOCK] = ilk_open || ilk_close;
        code_vec[acs_pkg::ACS_CODE_ESD_FAIL] = esd_on && !disc_stop;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers.

    // Channel history, dual mode owner and positioner state.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            chan_one_prev_reg <= acs_pkg::ACS_VAL_STOP;
            chan_two_prev_reg <= acs_pkg::ACS_VAL_STOP;
            sel_one_reg <= 1'b1;
            disc_prev_reg <= acs_pkg::ACS_DIR_STOP;
            pos_dir_reg <= acs_pkg::ACS_DIR_STOP;
            analog_active_reg <= 1'b0;
        end else begin
            chan_one_prev_reg <= net_cmd.chan_one;
            chan_two_prev_reg <= net_cmd.chan_two;
            sel_one_reg <= sel_one_now; // R5
            disc_prev_reg <= disc_cmd;
            pos_dir_reg <= pos_dir_next;
            analog_active_reg <= analog_active_next;
        end
    end

    // Setpoint memory; losing network power makes it absent and closed.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            target_reg <= acs_pkg::ACS_PCT_CLOSED;
            sp_known_reg <= 1'b0;
        end else if (!net_power_ok) begin
            target_reg <= acs_pkg::ACS_PCT_CLOSED; // R11
            sp_known_reg <= 1'b0; // R11
        end else if (sp_accept) begin
            target_reg <= sp_clamped;
            sp_known_reg <= 1'b1;
        end
    end

    // Second divider and seconds since the last positioner start.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sec_cnt_reg <= '0;
            inhibit_cnt_reg <= acs_pkg::ACS_INHIBIT_RST;
        end else begin
            sec_cnt_reg <= sec_tick ? '0 : sec_cnt_reg + 1'b1;
            if (pos_start) inhibit_cnt_reg <= 8'h00; // R14
            else if (sec_tick && (inhibit_cnt_reg != 8'hFF)) inhibit_cnt_reg <= inhibit_cnt_reg + 8'h01;
        end
    end

    // Motor drives and condition reports.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            motor_open_reg <= 1'b0;
            motor_close_reg <= 1'b0;
            report_one_reg <= 1'b0;
            report_two_reg <= 1'b0;
        end else begin
            motor_open_reg <= open_next;
            motor_close_reg <= close_next;
            report_one_reg <= code_bit(code_vec, report_one_code_select); // R15
            report_two_reg <= code_bit(code_vec, report_two_code_select); // R15
        end
    end

    assign motor_open = motor_open_reg;
    assign motor_close = motor_close_reg;
    assign condition_report_one = report_one_reg;
    assign condition_report_two = report_two_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    property p_inert_modes;
        @(posedge clk) disable iff (!rst_b) !net_mode |=> !motor_open_reg && !motor_close_reg;
    endproperty
    a_inert_modes: assert property (p_inert_modes) else $error("Inert source moved the motor."); // R1 R6

    property p_mono_one_open;
        @(posedge clk) disable iff (!rst_b)
        (source_select == 3'h1) && net_power_ok && !net_cmd.emergency_shutdown && (net_cmd.interlock == 2'h0)
        && (net_cmd.chan_one == 2'h1) && !limit_open && !torque_open && !motor_close_reg |=> motor_open_reg;
    endproperty
    a_mono_one_open: assert property (p_mono_one_open) else $error("Channel one open not obeyed."); // R2

    property p_alt_close;
        @(posedge clk) disable iff (!rst_b)
        (source_select == 3'h6) && net_power_ok && !net_cmd.emergency_shutdown && (net_cmd.interlock == 2'h0)
        && (net_cmd.chan_one == 2'h0) && !limit_closed && !torque_closed && !motor_open_reg |=> motor_close_reg;
    endproperty
    a_alt_close: assert property (p_alt_close) else $error("Alternate close not obeyed."); // R3

    property p_dual_latest;
        @(posedge clk) disable iff (!rst_b)
        (source_select == 3'h3) && net_power_ok && !one_changed && two_changed
        && (net_cmd.chan_two == 2'h2) |-> (disc_cmd == acs_pkg::ACS_DIR_CLOSE);
    endproperty
    a_dual_latest: assert property (p_dual_latest) else $error("Dual mode ignored latest change."); // R4 R5

    property p_esd_close;
        @(posedge clk) disable iff (!rst_b)
        net_live && net_cmd.emergency_shutdown && (esd_position == acs_pkg::ACS_DIR_CLOSE) && !limit_closed
        && !torque_closed && !motor_open_reg |=> motor_close_reg && !motor_open_reg;
    endproperty
    a_esd_close: assert property (p_esd_close) else $error("Emergency close not obeyed."); // R7

    property p_interlock_open;
        @(posedge clk) disable iff (!rst_b) ilk_open && !net_cmd.emergency_shutdown |=> !motor_open_reg;
    endproperty
    a_interlock_open: assert property (p_interlock_open) else $error("Interlock let the valve open."); // R8

    property p_setpoint_needs_stop;
        @(posedge clk) disable iff (!rst_b) !disc_stop |=> !analog_active_reg ##1 (pos_dir_reg == acs_pkg::ACS_DIR_STOP);
    endproperty
    a_setpoint_needs_stop: assert property (p_setpoint_needs_stop) else $error("Positioner ran under discrete."); // R9

    property p_repeat_ignored;
        @(posedge clk) disable iff (!rst_b)
        net_cmd.setpoint_strobe && net_power_ok && !analog_active_reg && sp_known_reg
        && (sp_clamped == target_reg) |=> !analog_active_reg || $past(disc_event) == 1'b0;
    endproperty
    a_repeat_ignored: assert property (p_repeat_ignored) else $error("Repeated setpoint was acted on."); // R10

    property p_power_loss;
        @(posedge clk) disable iff (!rst_b) !net_power_ok |=> (target_reg == 7'h00) && analog_active_reg;
    endproperty
    a_power_loss: assert property (p_power_loss) else $error("Power loss did not close setpoint."); // R11

    property p_band_start;
        @(posedge clk) disable iff (!rst_b) pos_start |-> (pos_err > deadband_pct) && (pos_err > hysteresis_pct);
    endproperty
    a_band_start: assert property (p_band_start) else $error("Start inside the band."); // R12 R13

    property p_inhibit;
        @(posedge clk) disable iff (!rst_b) pos_start |-> inhibit_ok ##1 (inhibit_cnt_reg == 8'h00);
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("Start inhibit not honoured."); // R14

    property p_report_one;
        @(posedge clk) disable iff (!rst_b) rst_b |=> report_one_reg == $past(code_bit(code_vec, report_one_code_select));
    endproperty
    a_report_one: assert property (p_report_one) else $error("Report one does not follow its code."); // R15

    property p_torque_variant;
        @(posedge clk) disable iff (!rst_b) !torque_seating |-> !code_vec[11] && !code_vec[12];
    endproperty
    a_torque_variant: assert property (p_torque_variant) else $error("Torque code without seating."); // R16 R17

    c_dual_switch: cover property (@(posedge clk) disable iff (!rst_b) (source_select == 3'h3) && two_changed);
    c_esd_drive: cover property (@(posedge clk) disable iff (!rst_b) esd_on ##1 motor_close_reg);
    c_pos_start: cover property (@(posedge clk) disable iff (!rst_b) pos_start);
    c_sp_ignored: cover property (@(posedge clk) disable iff (!rst_b) net_cmd.setpoint_strobe && net_live && !sp_accept);

endmodule

/* File: acs_net_partner.sv */
// Network controller model that sends the channels to the selector.
`timescale 1ns/1ns
module acs_net_partner (
    input wire logic clk, // Clock.
    input wire logic rst_b, // Reset, active low.
    input acs_pkg::acs_net_cmd_t want, // Channel values the bench wants sent.
    output acs_pkg::acs_net_cmd_t net_cmd // Channels as sent.
);
    logic seen_reg;
    ////////////////////////////////////////////////////////////////
    // Channels change once per cycle; a setpoint request goes out as a single strobe.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            net_cmd <= '0;
            seen_reg <= 1'b0;
        end else begin
            net_cmd <= want;
            net_cmd.setpoint_strobe <= want.setpoint_strobe & ~seen_reg;
            seen_reg <= want.setpoint_strobe;
        end
    end
endmodule

/* File: actuator_command_selector_tb.sv */
// Self-checking testbench for the actuator command selector.
`timescale 1ns/1ns
module actuator_command_selector_tb;
    logic clk = 1'b0, rst_b = 1'b0, pwr = 1'b1, mo, mc, r1, r2;
    logic [2:0] src = 3'h0;
    logic [6:0] pos = 7'h00;
    logic lo = 1'b0, lc = 1'b0, to = 1'b0, tc = 1'b0, ts = 1'b0;
    logic [3:0] aux = 4'h0;
    logic [5:0] c1 = 6'h00, c2 = 6'h00;
    logic [7:0] inh = 8'h00;
    acs_pkg::acs_dir_t esd_pos = acs_pkg::ACS_DIR_CLOSE;
    acs_pkg::acs_net_cmd_t want = '0, net_cmd;
    int n_fail = 0, samples_checked = 0;
    ////////////////////////////////////////////////////////////////
    // Design and the network partner.
    acs_net_partner u_net (.clk(clk), .rst_b(rst_b), .want(want), .net_cmd(net_cmd));
    acs_selector #(.TICKS_PER_SEC(10)) u_dut (.clk(clk), .rst_b(rst_b), .source_select(src), .net_cmd(net_cmd),
        .net_power_ok(pwr), .esd_position(esd_pos), .hysteresis_pct(7'h02), .deadband_pct(7'h02),
        .start_inhibit_interval(inh), .position_pct(pos), .limit_open(lo), .limit_closed(lc), .torque_open(to),
        .torque_closed(tc), .torque_seating(ts), .aux_in(aux), .report_one_code_select(c1),
        .report_two_code_select(c2), .motor_open(mo), .motor_close(mc), .condition_report_one(r1),
        .condition_report_two(r2));
    ////////////////////////////////////////////////////////////////
    // Helpers that wait, drive the channels and compare the outputs.
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic cmp(logic [1:0] e, logic [1:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // Checks settle just after an edge; the next stimulus then starts on a rising edge.
    task automatic chk_drive(logic [1:0] e);
        #1 cmp(e, {mo, mc});
        @(posedge clk);
    endtask
    task automatic chk_rep(logic [1:0] e);
        #1 cmp(e, {r1, r2});
        @(posedge clk);
    endtask
    task automatic set(logic [2:0] s, logic [1:0] a, logic [1:0] b);
        @(posedge clk);
        src <= s;
        want.chan_one <= a;
        want.chan_two <= b;
        cyc(5);
    endtask
    task automatic sp(logic [6:0] v);
        @(posedge clk);
        want.setpoint <= v;
        want.setpoint_strobe <= 1'b1;
        @(posedge clk);
        want.setpoint_strobe <= 1'b0;
        cyc(6);
    endtask
    ////////////////////////////////////////////////////////////////
    // Scenarios, one per task.
    task automatic t_modes;
        logic [1:0] exp_tab [8];
        exp_tab = '{2'h0, 2'h2, 2'h1, 2'h2, 2'h0, 2'h0, 2'h2, 2'h0};
        for (int s = 0; s < 8; s++) begin
            set(3'(s), 2'h1, 2'h2);
            chk_drive(exp_tab[s]);
        end
    endtask
    task automatic t_alt_dual;
        set(3'h6, 2'h0, 2'h0);
        chk_drive(2'h1);
        set(3'h3, 2'h1, 2'h0);
        set(3'h3, 2'h1, 2'h2);
        chk_drive(2'h1);
    endtask
    task automatic t_overrides;
        set(3'h1, 2'h1, 2'h0);
        want.emergency_shutdown <= 1'b1;
        cyc(5);
        chk_drive(2'h1);
        esd_pos <= acs_pkg::ACS_DIR_STOP;
        cyc(5);
        chk_drive(2'h0);
        want.emergency_shutdown <= 1'b0;
        want.interlock <= 2'h1;
        cyc(5);
        chk_drive(2'h0);
        want.interlock <= 2'h2;
        cyc(5);
        chk_drive(2'h2);
        want.interlock <= 2'h0;
    endtask
    task automatic t_setpoint;
        pos <= 7'h0A;
        set(3'h1, 2'h0, 2'h0);
        sp(7'h3C);
        chk_drive(2'h2);
        set(3'h1, 2'h2, 2'h0);
        set(3'h1, 2'h0, 2'h0);
        sp(7'h3C);
        chk_drive(2'h0);
        sp(7'h28);
        chk_drive(2'h2);
    endtask
    task automatic t_power;
        pos <= 7'h14;
        pwr <= 1'b0;
        cyc(3);
        pwr <= 1'b1;
        cyc(8);
        chk_drive(2'h1);
    endtask
    // Band blocks a small step; a second start waits for the inhibit interval.
    task automatic t_positioner;
        inh <= 8'h05;
        pos <= 7'h00;
        cyc(80);
        sp(7'h02);
        chk_drive(2'h0);
        sp(7'h0C);
        chk_drive(2'h2);
        pos <= 7'h0C;
        sp(7'h1E);
        chk_drive(2'h0);
        cyc(50);
        chk_drive(2'h2);
    endtask
    task automatic t_reports;
        c1 <= 6'h13;
        aux <= 4'h1;
        c2 <= 6'h0B;
        to <= 1'b1;
        cyc(3);
        chk_rep(2'h2);
        ts <= 1'b1;
        cyc(3);
        chk_rep(2'h3);
        c1 <= 6'h28;
        c2 <= 6'h0A;
        lc <= 1'b1;
        cyc(3);
        chk_rep(2'h1);
    endtask
    task automatic wrap_up;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // Clock, watchdog and main sequence.
    initial begin
        forever #10 clk = ~clk;
    end
    initial begin
        #100us;
        n_fail++;
        wrap_up();
    end
    initial begin
        cyc(12);
        rst_b <= 1'b1;
        t_modes();
        t_alt_dual();
        t_overrides();
        t_setpoint();
        t_power();
        t_positioner();
        t_reports();
        wrap_up();
    end
endmodule
